// File: hdl/i2sm_mem.sv
// sample memory: one port, registered read data
// assumes the owner issues at most one access per cycle
`default_nettype none
module i2sm_mem #(
	parameter int AW = 6,
	parameter int DW = 32
) (
	input  wire logic          clk,
	input  wire logic          en,
	input  wire logic          we,
	input  wire logic [AW-1:0] addr,
	input  wire logic [DW-1:0] wdata,
	output logic      [DW-1:0] rdata
);
	// ==========================================================
	// storage
	logic [DW-1:0] mem_q [0:(2**AW)-1];
	logic [DW-1:0] rdata_q;

	always_ff @(posedge clk) begin
		if (en && we) begin
			mem_q[addr] <= wdata;
		end
		if (en && !we) begin
			rdata_q <= mem_q[addr];
		end
	end

	assign rdata = rdata_q;
endmodule
`default_nettype wire

// File: hdl/i2sm_pkg.sv
// constants, field layouts and types shared by the i2s master block
// assumes a single 250 MHz fabric clock and an AXI4-Lite register bus
`default_nettype none
package i2sm_pkg;
	// ==========================================================
	// register map (byte addresses)
	localparam int          ADDR_W    = 12;
	localparam logic [11:0] OFF_CTRL  = 12'h000;
	localparam logic [11:0] OFF_STAT  = 12'h004;
	localparam logic [11:0] OFF_PTR   = 12'h008;
	localparam logic [1:0]  RAM_SEL   = 2'h1;
	localparam int          RAM_AW    = 6;
	localparam logic [1:0]  AXI_OKAY  = 2'h0;
	localparam logic [1:0]  AXI_SLV   = 2'h2;
	localparam logic [3:0]  STRB_ALL  = 4'hF;

	// ==========================================================
	// frame timing, in external count clock periods
	localparam int          CNT_W      = 8;
	localparam int          SCK_BIT    = 1;
	localparam int          WS_BIT     = 7;
	localparam logic [1:0]  FALL_PHASE = 2'h1;
	localparam logic [1:0]  RISE_PHASE = 2'h3;
	localparam logic [6:0]  EDGE_PHASE = 7'h7F;
	localparam logic [7:0]  WS_FALL_AT = 8'h7F;
	localparam logic [7:0]  LAG_STD    = 8'h04;
	localparam logic [7:0]  LAG_BACK   = 8'h00;
	localparam logic [7:0]  LAG_FWD    = 8'h00;
	localparam int          WORD_BITS  = 32;
	localparam int          SMP_BITS   = 24;
	localparam logic [5:0]  BITS_WORD  = 6'h20;
	localparam logic [7:0]  PAD_ZERO   = 8'h00;

	// ==========================================================
	// types
	typedef enum logic [1:0] {
		FMT_STD  = 2'h0,
		FMT_BACK = 2'h1,
		FMT_FWD  = 2'h2
	} i2sm_fmt_type;

	typedef struct packed {
		i2sm_fmt_type fmt;
		logic         tx_en;
		logic         right_en;
		logic         left_en;
		logic         run;
	} i2sm_ctrl_type;

	localparam int            CTRL_W     = 6;
	localparam i2sm_ctrl_type CTRL_RESET = 6'h00;

	typedef struct packed {
		logic [31:0] tx_sh;
		logic [31:0] rx_sh;
		logic [31:0] rx_word;
		logic [5:0]  cnt;
		logic        dout;
		logic        oe;
	} i2sm_chan_type;

	localparam i2sm_chan_type CHAN_RESET = '0;

	// ==========================================================
	// padding placement
	function automatic logic [7:0] lag_of(input i2sm_fmt_type f);
		unique case (f)
			FMT_BACK: lag_of = LAG_BACK;
			FMT_FWD:  lag_of = LAG_FWD;
			default:  lag_of = LAG_STD;
		endcase
	endfunction

	function automatic logic [31:0] pack_tx(input logic [23:0] s, input i2sm_fmt_type f);
		pack_tx = (f == FMT_FWD) ? {PAD_ZERO, s} : {s, PAD_ZERO};
	endfunction

	function automatic logic [31:0] unpack_rx(input logic [31:0] w, input i2sm_fmt_type f);
		unpack_rx = (f == FMT_FWD) ? {PAD_ZERO, w[23:0]} : {PAD_ZERO, w[31:8]};
	endfunction
endpackage
`default_nettype wire

// File: hdl/i2sm_top.sv
// i2s master: timer, two slave serial channels, transfer controller
// assumes ext count clock is asynchronous and the board ORs both outputs
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the placing of the registers.
`default_nettype none
module i2sm_top import i2sm_pkg::*; #(
	parameter int MEM_AW = RAM_AW
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic              external_count_clock_pin,
	input  wire logic              rx_data_pin,
	output logic                   bit_clock_output_pin,
	output logic                   word_select_output_pin,
	output logic                   strobe_output_pin,
	output logic                   left_dout,
	output logic                   left_dout_oe,
	output logic                   right_dout,
	output logic                   right_dout_oe,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready
);
	// ==========================================================
	// pin synchronisers and timer
	logic          ext_s1_q, ext_s2_q, ext_s3_q, rxd_s1_q, rxd_s2_q;
	logic [7:0]    cnt_q, cnt_d, strb_q, strb_d;
	logic          sck_q, sck_d, ws_q, ws_d, stb_q, stb_d;
	logic          tick, fall_ev, rise_ev, stb_edge;
	i2sm_ctrl_type ctrl_q, ctrl_d;

	assign tick     = ext_s2_q & ~ext_s3_q;
	assign fall_ev  = ctrl_q.run & tick & (cnt_q[1:0] == FALL_PHASE);
	assign rise_ev  = ctrl_q.run & tick & (cnt_q[1:0] == RISE_PHASE);
	assign stb_edge = ctrl_q.run & tick & (strb_q[6:0] == EDGE_PHASE)
	                  & (stb_q ^ strb_q[WS_BIT]);

	always_comb begin
		cnt_d  = cnt_q;
		strb_d = strb_q;
		if (!ctrl_q.run) begin
			cnt_d  = 8'h00;
			strb_d = 8'h00 - lag_of(ctrl_d.fmt);
		end else if (tick) begin
			cnt_d  = cnt_q + 8'h01;
			strb_d = strb_q + 8'h01;
		end
		sck_d = ~ctrl_q.run | ~cnt_d[SCK_BIT];
		ws_d  = ~ctrl_q.run | ~cnt_d[WS_BIT];
		stb_d = ~ctrl_q.run | (stb_q ^ stb_edge);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ext_s1_q <= 1'b0;
			ext_s2_q <= 1'b0;
			ext_s3_q <= 1'b0;
			rxd_s1_q <= 1'b0;
			rxd_s2_q <= 1'b0;
			cnt_q    <= 8'h00;
			strb_q   <= 8'h00;
			sck_q    <= 1'b1;
			ws_q     <= 1'b1;
			stb_q    <= 1'b1;
		end else begin
			ext_s1_q <= external_count_clock_pin;
			ext_s2_q <= ext_s1_q;
			ext_s3_q <= ext_s2_q;
			rxd_s1_q <= rx_data_pin;
			rxd_s2_q <= rxd_s1_q;
			cnt_q    <= cnt_d;
			strb_q   <= strb_d;
			sck_q    <= sck_d;
			ws_q     <= ws_d;
			stb_q    <= stb_d;
		end
	end

	assign bit_clock_output_pin   = sck_q;
	assign word_select_output_pin = ws_q;
	assign strobe_output_pin      = stb_q;

	// ==========================================================
	// serial channels: 0 left, 1 right
	i2sm_chan_type ch_q [2];
	i2sm_chan_type ch_d [2];
	logic [31:0]   hold_q [2];
	logic [31:0]   hold_d [2];
	logic [1:0]    reinit_q, reinit_d, fe, act_now, act_next;

	assign fe       = {ctrl_q.right_en, ctrl_q.left_en};
	assign act_now  = {stb_q, ~stb_q};
	assign act_next = {stb_d, ~stb_d};

	for (genvar i = 0; i < 2; i++) begin : g_chan
		always_comb begin
			ch_d[i] = ch_q[i];
			if (!(fe[i] && !reinit_q[i] && ctrl_q.run)) begin
				ch_d[i].tx_sh = '0;
				ch_d[i].rx_sh = '0;
				ch_d[i].cnt   = 6'h00;
				ch_d[i].dout  = 1'b0;
				ch_d[i].oe    = 1'b0;
			end else if (stb_edge) begin
				if (act_next[i]) begin
					ch_d[i].tx_sh = hold_q[i];
					ch_d[i].rx_sh = '0;
					ch_d[i].cnt   = 6'h00;
					ch_d[i].dout  = 1'b0;
					ch_d[i].oe    = 1'b1;
				end else begin
					ch_d[i].rx_word = ch_q[i].rx_sh;
					if (rise_ev && act_now[i] && ch_q[i].cnt < BITS_WORD) begin
						ch_d[i].rx_word = {ch_q[i].rx_sh[30:0], rxd_s2_q};
					end
					ch_d[i].dout    = 1'b0;
					ch_d[i].oe      = 1'b0;
				end
			end else if (act_now[i] && ch_q[i].cnt < BITS_WORD) begin
				if (fall_ev) begin
					ch_d[i].dout  = ch_q[i].tx_sh[WORD_BITS-1];
					ch_d[i].tx_sh = {ch_q[i].tx_sh[30:0], 1'b0};
				end
				if (rise_ev) begin
					ch_d[i].rx_sh = {ch_q[i].rx_sh[30:0], rxd_s2_q};
					ch_d[i].cnt   = ch_q[i].cnt + 6'h01;
				end
			end
			ch_d[i].oe = ch_d[i].oe & ctrl_q.tx_en;
			ch_d[i].dout = ch_d[i].dout & ch_d[i].oe;
		end

		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				ch_q[i] <= CHAN_RESET;
			end else begin
				ch_q[i] <= ch_d[i];
			end
		end
	end

	assign left_dout     = ch_q[0].dout;
	assign left_dout_oe  = ch_q[0].oe;
	assign right_dout    = ch_q[1].dout;
	assign right_dout_oe = ch_q[1].oe;

	// ==========================================================
	// transfer controller and register slave
	typedef enum logic [2:0] {
		S_IDLE, S_TX_RD, S_TX_LD, S_RX_WR, S_BUS_WR, S_BUS_RD, S_BUS_RD2
	} i2sm_state_type;

	i2sm_state_type   st_q, st_d;
	logic             cur_q, cur_d;
	logic [1:0]       pend_q, pend_d, pend_set, pend_clr;
	logic [MEM_AW-2:0] txp_q, txp_d, rxp_q, rxp_d;
	logic [15:0]      xfer_q, xfer_d;
	logic             awh_q, awh_d, wh_q, wh_d, arh_q, arh_d;
	logic [ADDR_W-1:0] awa_q, awa_d, ara_q, ara_d;
	logic [31:0]      wd_q, wd_d, rd_q, rd_d;
	logic [3:0]       ws_strb_q, ws_strb_d;
	logic             bv_q, bv_d, rv_q, rv_d;
	logic [1:0]       br_q, br_d, rr_q, rr_d;
	logic             m_en, m_we, aw_ram, ar_ram;
	logic [MEM_AW-1:0] m_addr;
	logic [31:0]      m_wdata, m_rdata, reg_rd;

	function automatic logic ram_hit(input logic [ADDR_W-1:0] a);
		ram_hit = (a[11:10] == RAM_SEL) && ({1'b0, a[9:2]} < 9'(2 ** MEM_AW));
	endfunction

	assign aw_ram   = ram_hit(awa_q);
	assign ar_ram   = ram_hit(ara_q);
	assign pend_set = {stb_edge & stb_q, stb_edge & ~stb_q};

	always_comb begin
		unique case (ara_q)
			OFF_CTRL: reg_rd = {26'h0, ctrl_q};
			OFF_STAT: reg_rd = {24'h0, st_q != S_IDLE, pend_q, reinit_q, stb_q, ws_q, sck_q};
			OFF_PTR:  reg_rd = {xfer_q, 8'(rxp_q), 8'(txp_q)};
			default:  reg_rd = 32'h0;
		endcase
	end

	always_comb begin
		st_d = st_q; cur_d = cur_q; txp_d = txp_q; rxp_d = rxp_q; xfer_d = xfer_q;
		ctrl_d = ctrl_q; hold_d = hold_q; reinit_d = 2'h0; pend_clr = 2'h0;
		awh_d = awh_q; awa_d = awa_q; wh_d = wh_q; wd_d = wd_q; ws_strb_d = ws_strb_q;
		arh_d = arh_q; ara_d = ara_q; bv_d = bv_q; br_d = br_q; rv_d = rv_q;
		rr_d = rr_q; rd_d = rd_q;
		m_en = 1'b0; m_we = 1'b0; m_addr = {1'b0, txp_q[MEM_AW-2:1], cur_q}; m_wdata = 32'h0;
		if (s_axi_awvalid && !awh_q) begin
			awh_d = 1'b1;
			awa_d = s_axi_awaddr;
		end
		if (s_axi_wvalid && !wh_q) begin
			wh_d      = 1'b1;
			wd_d      = s_axi_wdata;
			ws_strb_d = s_axi_wstrb;
		end
		if (s_axi_arvalid && !arh_q) begin
			arh_d = 1'b1;
			ara_d = s_axi_araddr;
		end
		if (bv_q && s_axi_bready) bv_d = 1'b0;
		if (rv_q && s_axi_rready) rv_d = 1'b0;
		unique case (st_q)
			S_IDLE: begin
				if (pend_q != 2'h0) begin
					cur_d = ~pend_q[0];
					st_d  = S_TX_RD;
				end else if (awh_q && wh_q && !bv_q) begin
					if (aw_ram) begin
						st_d = S_BUS_WR;
					end else begin
						if (awa_q == OFF_CTRL && ws_strb_q[0]) begin
							ctrl_d = i2sm_ctrl_type'(wd_q[CTRL_W-1:0]);
						end
						br_d = (awa_q == OFF_CTRL || awa_q == OFF_STAT || awa_q == OFF_PTR)
						       ? AXI_OKAY : AXI_SLV;
						bv_d = 1'b1; awh_d = 1'b0; wh_d = 1'b0;
					end
				end else if (arh_q && !rv_q) begin
					if (ar_ram) begin
						st_d = S_BUS_RD;
					end else begin
						rd_d = reg_rd;
						rr_d = (ara_q == OFF_CTRL || ara_q == OFF_STAT || ara_q == OFF_PTR)
						       ? AXI_OKAY : AXI_SLV;
						rv_d = 1'b1; arh_d = 1'b0;
					end
				end
			end
			S_TX_RD: begin
				m_en = 1'b1;
				st_d = S_TX_LD;
			end
			S_TX_LD: begin
				hold_d[cur_q] = pack_tx(m_rdata[SMP_BITS-1:0], ctrl_q.fmt);
				st_d          = S_RX_WR;
			end
			S_RX_WR: begin
				m_en            = 1'b1;
				m_we            = 1'b1;
				m_addr          = {1'b1, rxp_q};
				m_wdata         = unpack_rx(ch_q[cur_q].rx_word, ctrl_q.fmt);
				txp_d           = txp_q + 1'b1;
				rxp_d           = rxp_q + 1'b1;
				xfer_d          = xfer_q + 16'h0001;
				pend_clr[cur_q] = 1'b1;
				reinit_d[cur_q] = 1'b1;
				st_d            = S_IDLE;
			end
			S_BUS_WR: begin
				m_en    = 1'b1;
				m_we    = (ws_strb_q == STRB_ALL);
				m_addr  = awa_q[MEM_AW+1:2];
				m_wdata = wd_q;
				br_d    = AXI_OKAY;
				bv_d    = 1'b1; awh_d = 1'b0; wh_d = 1'b0;
				st_d    = S_IDLE;
			end
			S_BUS_RD: begin
				m_en   = 1'b1;
				m_addr = ara_q[MEM_AW+1:2];
				st_d   = S_BUS_RD2;
			end
			S_BUS_RD2: begin
				rd_d = m_rdata;
				rr_d = AXI_OKAY;
				rv_d = 1'b1; arh_d = 1'b0;
				st_d = S_IDLE;
			end
		endcase
		pend_d = (pend_q & ~pend_clr) | pend_set;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_q <= S_IDLE; cur_q <= 1'b0; pend_q <= 2'h0; reinit_q <= 2'h0;
			txp_q <= '0; rxp_q <= '0; xfer_q <= 16'h0000; ctrl_q <= CTRL_RESET;
			hold_q[0] <= 32'h0; hold_q[1] <= 32'h0;
			awh_q <= 1'b0; awa_q <= '0; wh_q <= 1'b0; wd_q <= 32'h0; ws_strb_q <= 4'h0;
			arh_q <= 1'b0; ara_q <= '0; bv_q <= 1'b0; br_q <= AXI_OKAY;
			rv_q <= 1'b0; rr_q <= AXI_OKAY; rd_q <= 32'h0;
		end else begin
			st_q <= st_d; cur_q <= cur_d; pend_q <= pend_d; reinit_q <= reinit_d;
			txp_q <= txp_d; rxp_q <= rxp_d; xfer_q <= xfer_d; ctrl_q <= ctrl_d;
			hold_q <= hold_d;
			awh_q <= awh_d; awa_q <= awa_d; wh_q <= wh_d; wd_q <= wd_d; ws_strb_q <= ws_strb_d;
			arh_q <= arh_d; ara_q <= ara_d; bv_q <= bv_d; br_q <= br_d;
			rv_q <= rv_d; rr_q <= rr_d; rd_q <= rd_d;
		end
	end

	assign s_axi_awready = ~awh_q;
	assign s_axi_wready  = ~wh_q;
	assign s_axi_arready = ~arh_q;
	assign s_axi_bvalid  = bv_q;
	assign s_axi_bresp   = br_q;
	assign s_axi_rvalid  = rv_q;
	assign s_axi_rresp   = rr_q;
	assign s_axi_rdata   = rd_q;

	i2sm_mem #(
		.AW(MEM_AW),
		.DW(WORD_BITS)
	) u_mem (
		.clk  (aclk),
		.en   (m_en),
		.we   (m_we),
		.addr (m_addr),
		.wdata(m_wdata),
		.rdata(m_rdata)
	);

	// ==========================================================
	// checks
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_left_leave;
		stb_edge && !stb_q;
	endsequence

	sequence s_left_taken;
		##[1:8] (st_q == S_RX_WR && !cur_q);
	endsequence

	sck_fall_a: assert property (fall_ev |=> !sck_q)
		else $error("bit clock did not fall");
	ws_fall_a: assert property (ctrl_q.run && tick && cnt_q == WS_FALL_AT |=> !ws_q)
		else $error("word select did not fall mid frame");
	strobe_lag_a: assert property (ctrl_q.run && ctrl_q.fmt == FMT_STD
		|-> strb_q == cnt_q - LAG_STD)
		else $error("strobe phase lag wrong");
	one_active_a: assert property (!(ch_q[0].oe && ch_q[1].oe))
		else $error("both channels driving");
	idle_hiz_a: assert property (stb_q && $past(stb_q) |-> !ch_q[0].oe)
		else $error("idle left channel driving");
	rx_only_a: assert property (!ctrl_q.tx_en |=> !ch_q[0].oe && !ch_q[1].oe)
		else $error("output enabled in receive only");
	left_req_a: assert property (s_left_leave |=> pend_q[0] ##0 s_left_taken)
		else $error("left transfer not serviced");
	reinit_clear_a: assert property (reinit_q[0] |=> ch_q[0].cnt == 6'h00 && !ch_q[0].oe)
		else $error("left channel not re-initialised");
	bresp_hold_a: assert property (bv_q && !s_axi_bready |=> bv_q && $stable(br_q))
		else $error("write response dropped");
endmodule
`default_nettype wire

// File: verification/i2sm_codec_model.sv
// far-side audio codec: count clock source, serial word sender and catcher
// assumes lag_bit is high for the one-bit-lag framing, low for zero lag
`default_nettype none
module i2sm_codec_model (
	output logic        count_clk,
	input  wire logic        sck,
	input  wire logic        ws,
	input  wire logic        l_dout,
	input  wire logic        l_oe,
	input  wire logic        r_dout,
	input  wire logic        r_oe,
	input  wire logic        lag_bit,
	input  wire logic [31:0] l_tx,
	input  wire logic [31:0] r_tx,
	output logic        rx_data,
	output logic [31:0] l_got,
	output logic [31:0] r_got
);
	timeunit 1ns;
	timeprecision 1ps;
	logic        ws_f = 1'b1;
	logic        ch = 1'b0;
	logic        line;
	logic        line_d = 1'b0;
	logic [31:0] sh = '0;
	int          n = 0;
	int          k = 32;
	initial count_clk = 1'b0;
	initial rx_data = 1'b0;
	initial l_got = '0;
	initial r_got = '0;
	// ==========================================================
	// oscillator and merged line
	always #40.690 count_clk = ~count_clk;
	assign line = (l_oe & l_dout) | (r_oe & r_dout);
	always @(line) line_d <= #10 line;
	// ==========================================================
	// word sender, msb first, channel from word select
	always @(negedge sck) begin
		if (ws !== ws_f) n = 0;
		ws_f = ws;
		if (n == int'(lag_bit)) rx_data <= ws ? r_tx[31] : l_tx[31];
		else if (k >= 1 && k <= 31) rx_data <= ch ? r_tx[31-k] : l_tx[31-k];
		else rx_data <= ~rx_data;
	end
	// ==========================================================
	// word catcher on bit clock rise
	always @(posedge sck) begin
		n = n + 1;
		if (n == int'(lag_bit) + 1) begin
			k = 1;
			ch = ws_f;
			sh = {31'h0, line_d};
		end else if (k < 32) begin
			k = k + 1;
			sh = {sh[30:0], line_d};
			if (k == 32 && ch) r_got <= sh;
			if (k == 32 && !ch) l_got <= sh;
		end
	end
endmodule
`default_nettype wire

// File: verification/i2sm_tb_top.sv
// self-checking bench for the i2s master: register access and codec traffic
// assumes the codec model supplies the count clock and the serial partner
`default_nettype none
module i2sm_tb_top import i2sm_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [23:0] SMP_L = 24'hC35A17;
	localparam logic [23:0] SMP_R = 24'h2E91B4;
	localparam logic [31:0] RX_L = 32'h9ABCDE12;
	localparam logic [31:0] RX_R = 32'h3456789A;
	localparam logic [11:0] RAM_BASE = 12'h400;
	logic aclk = 1'b0, aresetn = 1'b0, lag_bit = 1'b1, rxonly = 1'b0;
	logic external_count_clock_pin, rx_data_pin, bit_clock_output_pin;
	logic word_select_output_pin, strobe_output_pin;
	logic left_dout, left_dout_oe, right_dout, right_dout_oe;
	logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [31:0] s_axi_wdata = '0;
	logic [3:0] s_axi_wstrb = STRB_ALL;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata, l_got, r_got;
	logic sck_p = 1'b1, ws_p = 1'b1, stb_p = 1'b1;
	int nsck = 0, per_sck = 0, hi_c = 0, lo_c = 0, hi_len = 0, lo_len = 0;
	int lag_c = 0, lag_len = 0, overlap = 0, rx_drive = 0, bad_count = 0, comparisons = 0;
	always #2 aclk = ~aclk;
	i2sm_codec_model codec_u (.count_clk(external_count_clock_pin),
		.sck(bit_clock_output_pin), .ws(word_select_output_pin), .l_dout(left_dout),
		.l_oe(left_dout_oe), .r_dout(right_dout), .r_oe(right_dout_oe), .lag_bit,
		.l_tx(RX_L), .r_tx(RX_R), .rx_data(rx_data_pin), .l_got, .r_got);
	i2sm_top dut_u (.aclk, .aresetn, .external_count_clock_pin, .rx_data_pin,
		.bit_clock_output_pin, .word_select_output_pin, .strobe_output_pin,
		.left_dout, .left_dout_oe, .right_dout, .right_dout_oe,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready);
	// ==========================================================
	// pin timing monitor
	always @(posedge aclk) begin
		sck_p <= bit_clock_output_pin;
		ws_p <= word_select_output_pin;
		stb_p <= strobe_output_pin;
		lag_c <= lag_c + 1;
		if (bit_clock_output_pin && !sck_p) nsck <= nsck + 1;
		if (word_select_output_pin) hi_c <= hi_c + 1;
		else lo_c <= lo_c + 1;
		if (word_select_output_pin && !ws_p) begin
			per_sck <= nsck;
			nsck <= (bit_clock_output_pin && !sck_p) ? 1 : 0;
			lo_len <= lo_c;
			lo_c <= 0;
		end
		if (!word_select_output_pin && ws_p) begin
			hi_len <= hi_c;
			hi_c <= 0;
			lag_c <= 0;
		end
		if (!strobe_output_pin && stb_p) lag_len <= (!word_select_output_pin && ws_p) ? 0 : lag_c;
		if (left_dout_oe && right_dout_oe) overlap <= overlap + 1;
		if (rxonly && (left_dout_oe || right_dout_oe)) rx_drive <= rx_drive + 1;
	end
	// ==========================================================
	// checking and closing
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic fail_out;
		bad_count++;
		report_and_stop;
	endtask
	task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", what, e, g);
		end
	endtask
	// ==========================================================
	// axi4-lite master
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
		int t;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (t = 0; t < 100; t++) begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		if (t == 100) fail_out();
		chk("write resp", {30'h0, er}, {30'h0, s_axi_bresp});
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		int t;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (t = 0; t < 100; t++) begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		if (t == 100) fail_out();
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	task automatic rdchk(input string what, input logic [11:0] a, input logic [31:0] e,
			input logic [1:0] er);
		logic [31:0] d;
		logic [1:0]  r;
		rd(a, d, r);
		chk(what, e, d);
		chk("read resp", {30'h0, er}, {30'h0, r});
	endtask
	task automatic frames(input int n);
		int seen;
		seen = 0;
		for (int t = 0; t < n * 6000 && seen < n; t++) begin
			@(posedge aclk);
			if (word_select_output_pin && !ws_p) seen++;
		end
		if (seen < n) fail_out();
	endtask
	// ==========================================================
	// main sequence
	initial begin
		logic [31:0] d, a, b, el, er;
		logic [1:0]  r;
		logic [7:0]  p;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		rdchk("ctrl reset", OFF_CTRL, 32'h0, AXI_OKAY);
		rdchk("stat reset", OFF_STAT, 32'h7, AXI_OKAY);
		wr(OFF_STAT, 32'hFFFFFFFF, AXI_OKAY);
		rdchk("stat kept", OFF_STAT, 32'h7, AXI_OKAY);
		wr(12'h00C, 32'h1, AXI_SLV);
		rdchk("unmapped", 12'h00C, 32'h0, AXI_SLV);
		for (int i = 0; i < 32; i++)
			wr(RAM_BASE + 12'(4 * i), i[0] ? {8'h0, SMP_R} : {8'h0, SMP_L}, AXI_OKAY);
		rdchk("tx ram", RAM_BASE + 12'h004, {8'h0, SMP_R}, AXI_OKAY);
		for (int f = 0; f < 3; f++) begin
			lag_bit = (f == 0);
			wr(OFF_CTRL, {26'h0, f[1:0], 4'hF}, AXI_OKAY);
			frames(4);
			chk("left tx", (f == 2) ? {8'h0, SMP_L} : {SMP_L, 8'h0}, l_got);
			chk("right tx", (f == 2) ? {8'h0, SMP_R} : {SMP_R, 8'h0}, r_got);
			chk("sck per ws", 32'h40, per_sck);
			chk("ws halves", 32'h1, {31'h0, hi_len inside {[2602:2606]}
				&& lo_len inside {[2602:2606]}});
			chk("strobe lag", 32'h1, {31'h0, (f == 0) ? lag_len inside {[79:83]}
				: lag_len == 0});
			wr(OFF_CTRL, {26'h0, f[1:0], 4'h0}, AXI_OKAY);
			rd(OFF_PTR, d, r);
			p = d[15:8];
			rd(RAM_BASE + 12'(4 * (32 + ((p - 8'h1) & 8'h1F))), a, r);
			rd(RAM_BASE + 12'(4 * (32 + ((p - 8'h2) & 8'h1F))), b, r);
			el = (f == 2) ? {8'h0, RX_L[23:0]} : {8'h0, RX_L[31:8]};
			er = (f == 2) ? {8'h0, RX_R[23:0]} : {8'h0, RX_R[31:8]};
			chk("rx pair", 32'h1, {31'h0, (a === el && b === er)
				|| (a === er && b === el)});
		end
		rxonly = 1'b1;
		wr(OFF_CTRL, 32'h7, AXI_OKAY);
		frames(2);
		chk("rx only drive", 32'h0, rx_drive);
		chk("both driving", 32'h0, overlap);
		report_and_stop;
	end
endmodule
`default_nettype wire
